// [include/jdl_pkg.sv]
// Purpose: shared constants for the deterministic latency align block
// Assumes: register index times four is the wishbone byte address
// Notes:   latency figures are in encode clocks
`default_nettype none
package jdl_pkg;
    // ----------------------------------------
    // register indices and bus
    // ----------------------------------------
    localparam int             WB_ADR_W        = 16;
    localparam int             IDX_W           = 12;
    localparam logic [11:0]    IDX_SYSREF_CTRL = 12'h120;
    localparam logic [11:0]    IDX_MARGIN      = 12'h128;
    localparam logic [11:0]    IDX_LANE_RATE   = 12'h56E;
    localparam logic [11:0]    IDX_MF_OFFSET   = 12'h578;
    localparam logic [11:0]    IDX_SUBCLASS    = 12'h590;
    localparam logic [11:0]    IDX_APP_CFG     = 12'h5A0;
    localparam logic [11:0]    IDX_FRAME_CFG   = 12'h5A1;
    localparam logic [11:0]    IDX_LAT_STAT    = 12'h5A2;
    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int             SR_TRANS_BIT    = 4;
    localparam int             SR_EDGE_BIT     = 3;
    localparam int             SR_MODE_LSB     = 1;
    localparam logic [1:0]     SR_MODE_OFF     = 2'h0;
    localparam logic [1:0]     SR_MODE_CONT    = 2'h1;
    localparam logic [1:0]     SR_MODE_NSHOT   = 2'h2;
    localparam int             LANE_RATE_LSB   = 4;
    localparam int             SUBCLASS_LSB    = 5;
    localparam logic [2:0]     SUBCLASS_RST    = 3'h1;
    localparam logic [2:0]     SUBCLASS_0      = 3'h0;
    localparam int             APP_RATIO_LSB   = 4;
    localparam int             APP_CPLX_BIT    = 8;
    localparam int             FR_K_LSB        = 8;
    localparam int             FR_LEN_LSB      = 16;
    localparam logic [4:0]     FR_F_RST        = 5'h01;
    localparam logic [4:0]     FR_KM1_RST      = 5'h1F;
    localparam int             LAT_OK_BIT      = 15;
    localparam logic [3:0]     SETUP_SAT       = 4'hF;
    localparam logic [3:0]     HOLD_SAT        = 4'h8;
    // ----------------------------------------
    // application modes and ratio codes (0.5,1,2,4,8)
    // ----------------------------------------
    localparam logic [2:0]     APP_FULL        = 3'h0;
    localparam logic [2:0]     APP_DEC1        = 3'h1;
    localparam logic [2:0]     APP_DEC16       = 3'h5;
    localparam logic [2:0]     RATIO_HALF      = 3'h0;
    localparam logic [2:0]     RATIO_4         = 3'h3;
    localparam logic [2:0]     RATIO_8         = 3'h4;
    localparam logic [9:0]     LAT_FULL_ADC    = 10'd31;
    localparam logic [9:0]     LAT_FULL_HALF   = 10'd25;
    localparam logic [9:0]     ADC_LAT [6]     = '{10'd31, 10'd94, 10'd162, 10'd292,
                                                   10'd548, 10'd548};
    // zero marks a mode not supported at that ratio
    localparam logic [9:0]     LINK_LAT [6][5] = '{
        '{10'd25,  10'd14,  10'd7,  10'd4,  10'd2},
        '{10'd25,  10'd14,  10'd7,  10'd0,  10'd0},
        '{10'd46,  10'd27,  10'd14, 10'd7,  10'd0},
        '{10'd88,  10'd50,  10'd27, 10'd14, 10'd7},
        '{10'd172, 10'd96,  10'd50, 10'd27, 10'd14},
        '{10'd339, 10'd188, 10'd96, 10'd50, 10'd27}};
endpackage
`default_nettype wire

// [rtl/jdl_align.sv]
// Purpose: multiframe clock alignment, reference capture and latency report
// Assumes: sysref_i is asynchronous to ref_clk_i
// Notes:   latency values are reported, the data path lives elsewhere
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module jdl_align (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        sysref_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             frame_clk_o,
    output logic             lmfc_o,
    output logic             sample_div_reset_o,
    output logic      [2:0]  subclass_o,
    output logic      [3:0]  lane_rate_range_o,
    output logic      [9:0]  total_latency_o,
    output logic             config_supported_o
);
    typedef enum logic {JDL_SR_IDLE, JDL_SR_ARMED} jdl_sr_e;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [5:0] eff_offset(input logic [4:0] off, input logic [4:0] f,
                                              input logic [4:0] km1);
        logic [5:0] e;
        e = {1'b0, off};
        if (f == 5'h01) begin
            e = {3'h0, off[4:2]};
        end else if (f == 5'h02) begin
            e = {2'h0, off[4:1]};
        end
        // offsets past the multiframe wrap once; an offset of 2K or more stays at or above K
        if (e > {1'b0, km1}) begin
            e = e - ({1'b0, km1} + 6'h01);
        end
        return e;
    endfunction

    function automatic logic hit(input logic [11:0] idx);
        return wb_adr_i[13:2] == idx;
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [1:0]  sr_mode_q;
    logic        sr_trans_q;
    logic        sr_edge_q;
    logic [3:0]  lane_rate_q;
    logic [4:0]  mf_off_q;
    logic [2:0]  subclass_q;
    logic [2:0]  app_mode_q;
    logic [2:0]  app_ratio_q;
    logic        app_cplx_q;
    logic [4:0]  fr_f_q;
    logic [4:0]  fr_km1_q;
    logic [3:0]  fr_len_q;
    logic [3:0]  setup_q;
    logic [3:0]  hold_q;
    logic [9:0]  adc_lat_q;
    logic [9:0]  link_lat_q;
    logic        wr_stb;
    logic        sr_event;
    logic        nshot_done;
    jdl_sr_e     sr_state_q;

    assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sr_trans_q  <= 1'b0;
            sr_edge_q   <= 1'b0;
            lane_rate_q <= '0;
            mf_off_q    <= '0;
            subclass_q  <= jdl_pkg::SUBCLASS_RST;
        end else if (wr_stb) begin
            if (hit(jdl_pkg::IDX_SYSREF_CTRL)) begin
                sr_trans_q <= wb_dat_i[jdl_pkg::SR_TRANS_BIT];
                sr_edge_q  <= wb_dat_i[jdl_pkg::SR_EDGE_BIT];
            end
            if (hit(jdl_pkg::IDX_LANE_RATE)) begin
                lane_rate_q <= wb_dat_i[jdl_pkg::LANE_RATE_LSB +: 4];
            end
            if (hit(jdl_pkg::IDX_MF_OFFSET)) begin
                mf_off_q <= wb_dat_i[4:0];
            end
            if (hit(jdl_pkg::IDX_SUBCLASS)) begin
                subclass_q <= wb_dat_i[jdl_pkg::SUBCLASS_LSB +: 3];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            app_mode_q  <= jdl_pkg::APP_FULL;
            app_ratio_q <= jdl_pkg::RATIO_HALF;
            app_cplx_q  <= 1'b0;
            fr_f_q      <= jdl_pkg::FR_F_RST;
            fr_km1_q    <= jdl_pkg::FR_KM1_RST;
            fr_len_q    <= '0;
        end else if (wr_stb && hit(jdl_pkg::IDX_APP_CFG)) begin
            app_mode_q  <= wb_dat_i[2:0];
            app_ratio_q <= wb_dat_i[jdl_pkg::APP_RATIO_LSB +: 3];
            app_cplx_q  <= wb_dat_i[jdl_pkg::APP_CPLX_BIT];
        end else if (wr_stb && hit(jdl_pkg::IDX_FRAME_CFG)) begin
            fr_f_q   <= wb_dat_i[4:0];
            fr_km1_q <= wb_dat_i[jdl_pkg::FR_K_LSB +: 5];
            fr_len_q <= wb_dat_i[jdl_pkg::FR_LEN_LSB +: 4];
        end
    end

    // software write re-arms even when a one-shot completes the same cycle
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sr_mode_q  <= jdl_pkg::SR_MODE_OFF;
            sr_state_q <= JDL_SR_IDLE;
        end else if (wr_stb && hit(jdl_pkg::IDX_SYSREF_CTRL)) begin
            sr_mode_q  <= wb_dat_i[jdl_pkg::SR_MODE_LSB +: 2];
            sr_state_q <= (wb_dat_i[jdl_pkg::SR_MODE_LSB +: 2] != jdl_pkg::SR_MODE_OFF)
                          ? JDL_SR_ARMED : JDL_SR_IDLE;
        end else begin
            case (sr_state_q)
                JDL_SR_IDLE: begin
                    sr_state_q <= JDL_SR_IDLE;
                end
                JDL_SR_ARMED: begin
                    if (nshot_done) begin
                        sr_mode_q  <= jdl_pkg::SR_MODE_OFF;
                        sr_state_q <= JDL_SR_IDLE;
                    end
                end
                default: begin
                    sr_state_q <= JDL_SR_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // reference capture
    // ----------------------------------------
    logic [1:0] sr_pos_q;
    logic       sr_neg_q;
    logic [1:0] sr_negs_q;
    logic       sr_sel;
    logic       sr_prev_q;
    logic [3:0] stable_q;
    logic       hold_run_q;

    // falling-edge path: negedge first stage, then two rising-edge stages
    always_ff @(negedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sr_neg_q <= 1'b0;
        end else begin
            sr_neg_q <= sysref_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sr_pos_q  <= '0;
            sr_negs_q <= '0;
            sr_prev_q <= 1'b0;
        end else begin
            sr_pos_q  <= {sr_pos_q[0], sysref_i};
            sr_negs_q <= {sr_negs_q[0], sr_neg_q};
            sr_prev_q <= sr_sel;
        end
    end

    assign sr_sel     = sr_edge_q ? sr_negs_q[1] : sr_pos_q[1];
    assign sr_event   = (sr_state_q == JDL_SR_ARMED) &&
                        (sr_trans_q ? (sr_prev_q && !sr_sel)
                                    : (!sr_prev_q && sr_sel));
    assign nshot_done = sr_event && (sr_mode_q == jdl_pkg::SR_MODE_NSHOT);

    // margin monitor: stable cycles before and after the chosen transition
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stable_q   <= '0;
            setup_q    <= '0;
            hold_q     <= '0;
            hold_run_q <= 1'b0;
        end else begin
            if (sr_sel != sr_prev_q) begin
                stable_q <= '0;
            end else if (stable_q != jdl_pkg::SETUP_SAT) begin
                stable_q <= stable_q + 4'h1;
            end
            if (sr_event) begin
                setup_q    <= stable_q;
                hold_q     <= '0;
                hold_run_q <= 1'b1;
            end else if (hold_run_q) begin
                if (sr_sel != sr_prev_q || hold_q == jdl_pkg::HOLD_SAT) begin
                    hold_run_q <= 1'b0;
                end else begin
                    hold_q <= hold_q + 4'h1;
                end
            end
        end
    end

    // ----------------------------------------
    // frame and multiframe clocks
    // ----------------------------------------
    logic [3:0] div_q;
    logic [4:0] frame_q;
    logic       realign;
    logic [5:0] eff_off;

    assign realign = sr_event && (subclass_q != jdl_pkg::SUBCLASS_0);
    assign eff_off = eff_offset(mf_off_q, fr_f_q, fr_km1_q);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q   <= '0;
            frame_q <= '0;
        end else if (realign) begin
            div_q   <= '0;
            frame_q <= '0;
        end else if (div_q >= fr_len_q) begin
            div_q   <= '0;
            frame_q <= (frame_q >= fr_km1_q) ? 5'h00 : frame_q + 5'h01;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_clk_o        <= 1'b0;
            lmfc_o             <= 1'b0;
            sample_div_reset_o <= 1'b0;
        end else begin
            frame_clk_o        <= (div_q == 4'h0);
            lmfc_o             <= (div_q == 4'h0) && ({1'b0, frame_q} == eff_off);
            sample_div_reset_o <= realign;
        end
    end

    // ----------------------------------------
    // latency report
    // ----------------------------------------
    logic       supported;
    logic [2:0] adc_idx;

    always_comb begin
        adc_idx = app_mode_q;
        if (app_cplx_q && app_mode_q != jdl_pkg::APP_FULL) begin
            adc_idx = app_mode_q - 3'h1;
        end
        supported = (app_mode_q <= jdl_pkg::APP_DEC16) && (app_ratio_q <= jdl_pkg::RATIO_8);
        if (supported) begin
            supported = link_ok(app_mode_q, app_ratio_q);
        end
        if (app_mode_q == jdl_pkg::APP_DEC1 && app_cplx_q) begin
            supported = 1'b0;
        end
        if (app_mode_q == jdl_pkg::APP_DEC16 && app_ratio_q != jdl_pkg::RATIO_4) begin
            supported = supported &&
                        (app_cplx_q == (app_ratio_q != jdl_pkg::RATIO_HALF));
        end
    end

    function automatic logic link_ok(input logic [2:0] m, input logic [2:0] r);
        return jdl_pkg::LINK_LAT[m][r] != 10'd0;
    endfunction

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            adc_lat_q          <= '0;
            link_lat_q         <= '0;
            total_latency_o    <= '0;
            config_supported_o <= 1'b0;
        end else begin
            adc_lat_q          <= supported ? jdl_pkg::ADC_LAT[adc_idx] : 10'd0;
            link_lat_q         <= supported ? jdl_pkg::LINK_LAT[app_mode_q][app_ratio_q]
                                            : 10'd0;
            total_latency_o    <= adc_lat_q + link_lat_q;
            config_supported_o <= supported;
        end
    end

    // ----------------------------------------
    // wishbone slave: one wait state, unmapped reads zero
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= '0;
            if (hit(jdl_pkg::IDX_SYSREF_CTRL)) begin
                wb_dat_o[4:0] <= {sr_trans_q, sr_edge_q, sr_mode_q, 1'b0};
            end else if (hit(jdl_pkg::IDX_MARGIN)) begin
                wb_dat_o[7:0] <= {hold_q, setup_q};
            end else if (hit(jdl_pkg::IDX_LANE_RATE)) begin
                wb_dat_o[7:4] <= lane_rate_q;
            end else if (hit(jdl_pkg::IDX_MF_OFFSET)) begin
                wb_dat_o[4:0] <= mf_off_q;
            end else if (hit(jdl_pkg::IDX_SUBCLASS)) begin
                wb_dat_o[7:5] <= subclass_q;
            end else if (hit(jdl_pkg::IDX_APP_CFG)) begin
                wb_dat_o[8:0] <= {app_cplx_q, 1'b0, app_ratio_q, 1'b0, app_mode_q};
            end else if (hit(jdl_pkg::IDX_FRAME_CFG)) begin
                wb_dat_o[19:0] <= {fr_len_q, 3'h0, fr_km1_q, 3'h0, fr_f_q};
            end else if (hit(jdl_pkg::IDX_LAT_STAT)) begin
                wb_dat_o[15:0] <= {config_supported_o, 5'h00, total_latency_o};
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            subclass_o        <= jdl_pkg::SUBCLASS_RST;
            lane_rate_range_o <= '0;
        end else begin
            subclass_o        <= subclass_q;
            lane_rate_range_o <= lane_rate_q;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_full_adc_lat: assert property ((app_mode_q == jdl_pkg::APP_FULL)
        && !app_cplx_q && $stable(app_mode_q) |=> adc_lat_q == jdl_pkg::LAT_FULL_ADC)
        else $error("full mode converter latency wrong");
    chk_full_link_lat: assert property ((app_mode_q == jdl_pkg::APP_FULL)
        && (app_ratio_q == jdl_pkg::RATIO_HALF) |=> link_lat_q == jdl_pkg::LAT_FULL_HALF)
        else $error("full mode link latency wrong");
    chk_cplx_link_same: assert property ($changed(app_cplx_q) && $stable(app_mode_q)
        && $stable(app_ratio_q) && supported && $past(supported)
        |=> $stable(link_lat_q))
        else $error("link latency moved with data type");
    chk_total_sum: assert property (##1 total_latency_o
        == $past(adc_lat_q) + $past(link_lat_q))
        else $error("total latency not the sum");
    chk_dec1_reject: assert property ((app_mode_q == jdl_pkg::APP_DEC1)
        && (app_ratio_q >= jdl_pkg::RATIO_4) |=> !config_supported_o)
        else $error("unsupported mode accepted");
    chk_sub0_no_align: assert property (sr_event
        && (subclass_q == jdl_pkg::SUBCLASS_0) |=> !sample_div_reset_o)
        else $error("subclass zero realigned");
    chk_realign_zero: assert property (realign
        |=> div_q == 4'h0 && frame_q == 5'h00 ##1 frame_clk_o)
        else $error("realign did not reset dividers");
    chk_lmfc_phase: assert property (lmfc_o |-> $past(div_q) == 4'h0
        && {1'b0, $past(frame_q)} == $past(eff_off))
        else $error("multiframe clock at wrong frame");
    chk_rise_select: assert property (sr_event && !sr_trans_q
        |-> sr_sel && !$past(sr_sel))
        else $error("wrong reference transition");
    chk_nshot_clear: assert property (nshot_done && !wr_stb
        |=> sr_mode_q == jdl_pkg::SR_MODE_OFF && sr_state_q == JDL_SR_IDLE)
        else $error("one-shot mode did not self clear");
endmodule
`default_nettype wire

// [tb/jdl_rx_model.sv]
// Purpose: far-side model, reference pulse source and multiframe monitor
// Assumes: shares the encode clock with the transmitter
// Notes:   period_o holds the last measured multiframe length in cycles
`timescale 1ns/1ps
`default_nettype none
module jdl_rx_model #(
    parameter int W = 12
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        fire_i,
    input  wire logic        lmfc_i,
    output logic             sysref_o,
    output logic      [15:0] period_o
);
    logic [4:0]  hi_q;
    logic [15:0] cnt_q;
    // wide pulse so hold margin can reach saturation
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) hi_q <= 5'h00;
        else if (fire_i) hi_q <= 5'(W);
        else if (hi_q != 5'h00) hi_q <= hi_q - 5'h01;
    end
    assign sysref_o = (hi_q != 5'h00);
    // receive boundary follows the incoming marker
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q    <= 16'h0000;
            period_o <= 16'h0000;
        end else if (lmfc_i) begin
            period_o <= cnt_q + 16'h0001;
            cnt_q    <= 16'h0000;
        end else cnt_q <= cnt_q + 16'h0001;
    end
endmodule
`default_nettype wire

// [tb/jdl_align_bench.sv]
// Purpose: register and alignment tests for the latency align block
// Assumes: one register access per bus cycle, ack within a few cycles
// Notes:   frame of 2 clocks, 4 frames a multiframe in offset tests
`timescale 1ns/1ps
`default_nettype none
module jdl_align_bench;
    logic        clk, rst_n, sysref, fire, we, cyc, stb, ack, fclk, lmfc, divr, sup;
    logic [15:0] adr, period;
    logic [31:0] wdat, rd, dat_o;
    logic [3:0]  sel, lrr;
    logic [2:0]  subcl;
    logic [9:0]  lat;
    int          fail_count, num_checks, t0, td, tl, e;
    int          ff[5] = '{1, 1, 2, 2, 4};
    int          of[5] = '{3, 4, 1, 2, 3};
    int          ef[5] = '{0, 1, 0, 1, 3};

    jdl_align u_jdl_align (.ref_clk_i(clk), .rst_n_i(rst_n), .sysref_i(sysref),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .frame_clk_o(fclk),
        .lmfc_o(lmfc), .sample_div_reset_o(divr), .subclass_o(subcl),
        .lane_rate_range_o(lrr), .total_latency_o(lat), .config_supported_o(sup));
    jdl_rx_model u_jdl_rx_model (.clk_i(clk), .rst_n_i(rst_n), .fire_i(fire),
        .lmfc_i(lmfc), .sysref_o(sysref), .period_o(period));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wb(input logic w, input logic [11:0] idx, input logic [31:0] d);
        int n;
        @(posedge clk);
        adr <= {2'h0, idx, 2'h0};
        wdat <= d;
        we <= w;
        cyc <= 1'b1;
        stb <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        if (n == 20) begin
            fail_count++;
            wrap_up();
        end
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // fire one reference pulse, time realign and following marker
    task pulse();
        td = -1;
        tl = -1;
        @(posedge clk) fire <= 1'b1;
        @(posedge clk) fire <= 1'b0;
        for (int n = 0; n < 80; n++) begin
            @(posedge clk);
            #1;
            if (divr === 1'b1 && td < 0) td = n;
            else if (td >= 0 && tl < 0 && lmfc === 1'b1) tl = n - td;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst_n, fire, we, cyc, stb} = 5'h00;
        adr = 16'h0000;
        wdat = 32'h0000_0000;
        sel = 4'hF;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("subclass", 32'(subcl), 32'h1);
        chk("latency", 32'(lat), 32'd56);
        wb(1'b0, 12'h7F0, 32'h0);
        chk("unmapped", rd, 32'h0);
        wb(1'b1, jdl_pkg::IDX_LANE_RATE, 32'h50);
        repeat (2) @(posedge clk);
        chk("lane rate", 32'(lrr), 32'h5);
        $display("test registers done");
        for (int m = 0; m < 6; m++) for (int r = 0; r < 5; r++) for (int c = 0; c < 2; c++) begin
            if (m == 0 && c == 1) continue;
            e = (jdl_pkg::LINK_LAT[m][r] != 0) && !(m == 1 && c == 1) &&
                !(m == 5 && ((r == 0 && c == 1) || (r != 0 && r != 3 && c == 0)));
            wb(1'b1, jdl_pkg::IDX_APP_CFG, 32'((c << 8) | (r << 4) | m));
            repeat (4) @(posedge clk);
            chk("supported", 32'(sup), 32'(e));
            e = e ? jdl_pkg::ADC_LAT[c ? m - 1 : m] + jdl_pkg::LINK_LAT[m][r] : 0;
            chk("total", 32'(lat), 32'(e));
        end
        wb(1'b1, jdl_pkg::IDX_APP_CFG, 32'h0000_0103);
        repeat (4) @(posedge clk);
        chk("dec4 complex", 32'(lat), 32'd250);
        $display("test latency table done");
        wb(1'b1, jdl_pkg::IDX_FRAME_CFG, 32'h0001_0301);
        wb(1'b1, jdl_pkg::IDX_SUBCLASS, 32'h0);
        wb(1'b1, jdl_pkg::IDX_SYSREF_CTRL, 32'h2);
        pulse();
        chk("sc0 realign", 32'(td), 32'hFFFF_FFFF);
        wb(1'b1, jdl_pkg::IDX_SUBCLASS, 32'h20);
        pulse();
        t0 = tl;
        chk("lmfc spread", 32'(tl >= 0 && tl < 32'(period)), 32'h1);
        chk("rise event", 32'(td < 10), 32'h1);
        wb(1'b0, jdl_pkg::IDX_MARGIN, 32'h0);
        chk("margin", rd, 32'h8F);
        chk("period", 32'(period), 32'h8);
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, jdl_pkg::IDX_FRAME_CFG, 32'(32'h0001_0300 | ff[i]));
            wb(1'b1, jdl_pkg::IDX_MF_OFFSET, 32'(of[i]));
            pulse();
            chk("offset", 32'(tl), 32'(t0 + 2 * ef[i]));
        end
        wb(1'b1, jdl_pkg::IDX_MF_OFFSET, 32'h0);
        wb(1'b1, jdl_pkg::IDX_SYSREF_CTRL, 32'h12);
        pulse();
        chk("fall event", 32'(td >= 10), 32'h1);
        wb(1'b1, jdl_pkg::IDX_SYSREF_CTRL, 32'h0A);
        pulse();
        chk("clk edge", 32'(td >= 0 && td < 10), 32'h1);
        wb(1'b1, jdl_pkg::IDX_SYSREF_CTRL, 32'h4);
        pulse();
        chk("shot event", 32'(td >= 0 && td < 10), 32'h1);
        wb(1'b0, jdl_pkg::IDX_SYSREF_CTRL, 32'h0);
        chk("shot clear", rd, 32'h0);
        pulse();
        chk("shot spent", 32'(td), 32'hFFFF_FFFF);
        $display("test alignment done");
        wrap_up();
    end
endmodule
`default_nettype wire
